// file: logic/pwfms_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pwfms_defines.svh"

module pwfms_top #(
    parameter int FLOWS    = 8,
    parameter int SESSIONS = 16
) (
    input  wire logic                          mclk,
    input  wire logic                          srst,
    // configuration written by control software from core-chosen values
    input  wire logic [`PWFMS_DSCP_W-1:0]      ctrl_dscp,
    input  wire logic [`PWFMS_DSCP_W-1:0]      sess_dscp_wdata,
    input  wire logic [`PWFMS_SESS_W-1:0]      sess_dscp_waddr,
    input  wire logic                          sess_dscp_we,
    input  wire logic [`PWFMS_DSCP_W-1:0]      flow_phb_wdata,
    input  wire logic [`PWFMS_FLOW_W-1:0]      flow_phb_waddr,
    input  wire logic                          flow_phb_we,
    input  wire logic [`PWFMS_LEN_W-1:0]       mtu_wdata,
    input  wire logic [`PWFMS_SESS_W-1:0]      mtu_waddr,
    input  wire logic                          mtu_we,
    input  wire logic [`PWFMS_LEN_W-1:0]       own_mtu,
    input  wire logic                          seq_reset,
    // session admission check
    input  wire logic                          adm_valid,
    input  wire logic [`PWFMS_LEN_W-1:0]       adm_core_mtu,
    input  wire logic [`PWFMS_LEN_W-1:0]       adm_need,
    output logic                               adm_done,
    output logic                               adm_refuse,
    output logic [`PWFMS_LEN_W-1:0]            adm_reply_mtu,
    // upstream transmit path
    input  wire logic                          tx_valid,
    input  wire pwfms_pkg::pwfms_tx_type       tx_desc,
    output logic                               mark_valid,
    output pwfms_pkg::pwfms_mark_type          mark_desc,
    output logic                               tx_oversize,
    // downstream receive path
    input  wire logic                          rx_valid,
    input  wire pwfms_pkg::pwfms_rx_type       rx_desc,
    output logic                               fwd_valid,
    output pwfms_pkg::pwfms_fwd_type           fwd_desc,
    output logic                               gap_event,
    output logic                               late_drop,
    output logic [`PWFMS_GAPCNT_W-1:0]         gap_count
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (FLOWS < 1 || FLOWS > (1 << `PWFMS_FLOW_W)) begin : g_flows_bad
        $error("FLOWS out of range");
    end
    if (SESSIONS < 1 || SESSIONS > (1 << `PWFMS_SESS_W)) begin : g_sess_bad
        $error("SESSIONS out of range");
    end
    if (`PWFMS_MTU_MIN > ((1 << `PWFMS_LEN_W) - 1)) begin : g_mtu_bad
        $error("minimum MTU does not fit the length field");
    end
    if (`PWFMS_MTU_RST < `PWFMS_MTU_MIN) begin : g_mtu_rst_bad
        $error("reset MTU below the required minimum");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    localparam logic [`PWFMS_SEQ_W-1:0]    SEQ_ONE = {{(`PWFMS_SEQ_W-1){1'b0}}, 1'b1};
    localparam logic [`PWFMS_GAPCNT_W-1:0] GAP_ONE = {{(`PWFMS_GAPCNT_W-1){1'b0}}, 1'b1};

    // narrower parameters must never index past the end of a table
    function automatic logic sess_in_range(input logic [`PWFMS_SESS_W-1:0] idx);
        return 32'(idx) < SESSIONS;
    endfunction : sess_in_range

    function automatic logic flow_in_range(input logic [`PWFMS_FLOW_W-1:0] idx);
        return 32'(idx) < FLOWS;
    endfunction : flow_in_range

    function automatic logic below_floor(input logic [`PWFMS_LEN_W-1:0] mtu);
        return mtu < `PWFMS_MTU_MIN;
    endfunction : below_floor

    // holds at all ones so software never sees the count wrap to zero
    function automatic logic [`PWFMS_GAPCNT_W-1:0] sat_inc(
        input logic [`PWFMS_GAPCNT_W-1:0] v
    );
        return (v == '1) ? v : v + GAP_ONE;
    endfunction : sat_inc

    // ------------------------------------------------------------
    // configuration tables
    // ------------------------------------------------------------
    logic [`PWFMS_DSCP_W-1:0] sess_dscp_reg [SESSIONS];
    logic [`PWFMS_DSCP_W-1:0] flow_phb_reg  [FLOWS];
    logic [`PWFMS_LEN_W-1:0]  mtu_reg       [SESSIONS];

    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < SESSIONS; i++) begin
                sess_dscp_reg[i] <= `PWFMS_DSCP_RST;
            end
        end else if (sess_dscp_we && sess_in_range(sess_dscp_waddr)) begin
            sess_dscp_reg[sess_dscp_waddr] <= sess_dscp_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < FLOWS; i++) begin
                flow_phb_reg[i] <= `PWFMS_DSCP_RST;
            end
        end else if (flow_phb_we && flow_in_range(flow_phb_waddr)) begin
            flow_phb_reg[flow_phb_waddr] <= flow_phb_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < SESSIONS; i++) begin
                mtu_reg[i] <= `PWFMS_MTU_RST;
            end
        end else if (mtu_we && sess_in_range(mtu_waddr)) begin
            mtu_reg[mtu_waddr] <= mtu_wdata;
        end
    end

    // ------------------------------------------------------------
    // session admission
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            adm_done      <= 1'b0;
            adm_refuse    <= 1'b0;
            adm_reply_mtu <= `PWFMS_MTU_RST;
        end else begin
            adm_done <= adm_valid;
            if (adm_valid) begin
                adm_refuse    <= (adm_need > adm_core_mtu) ||
                                 below_floor(adm_core_mtu);
                adm_reply_mtu <= below_floor(own_mtu) ?
                                 `PWFMS_MTU_MIN : own_mtu;
            end
        end
    end

    // ------------------------------------------------------------
    // upstream marking
    // ------------------------------------------------------------
    logic [`PWFMS_DSCP_W-1:0] tx_dscp;
    logic                     tx_fits;

    always_comb begin
        tx_dscp = `PWFMS_DSCP_RST;
        unique case (tx_desc.kind)
            pwfms_pkg::PWFMS_KIND_CTRL: begin
                tx_dscp = ctrl_dscp;
            end
            pwfms_pkg::PWFMS_KIND_SESS: begin
                if (sess_in_range(tx_desc.session)) begin
                    tx_dscp = sess_dscp_reg[tx_desc.session];
                end
            end
            pwfms_pkg::PWFMS_KIND_FLOW: begin
                if (flow_in_range(tx_desc.flow)) begin
                    tx_dscp = flow_phb_reg[tx_desc.flow];
                end
            end
            default: begin
                tx_dscp = ctrl_dscp;
            end
        endcase
    end

    assign tx_fits = (tx_desc.kind == pwfms_pkg::PWFMS_KIND_CTRL) ||
                     (sess_in_range(tx_desc.session) &&
                      tx_desc.length <= mtu_reg[tx_desc.session]);

    always_ff @(posedge mclk) begin
        if (srst) begin
            mark_valid  <= 1'b0;
            tx_oversize <= 1'b0;
            mark_desc   <= '0;
        end else begin
            mark_valid  <= tx_valid && tx_fits;
            tx_oversize <= tx_valid && !tx_fits;
            if (tx_valid) begin
                mark_desc.dscp      <= tx_dscp;
                mark_desc.dont_frag <= 1'b1;
                mark_desc.session   <= tx_desc.session;
                mark_desc.flow      <= tx_desc.flow;
                mark_desc.length    <= tx_desc.length;
            end
        end
    end

    // ------------------------------------------------------------
    // downstream sequence check
    // ------------------------------------------------------------
    function automatic pwfms_pkg::pwfms_seq_type classify(
        input logic [`PWFMS_SEQ_W-1:0] got,
        input logic [`PWFMS_SEQ_W-1:0] want,
        input logic                    seen
    );
        logic [`PWFMS_SEQ_W-1:0] diff;
        diff = got - want;
        if (!seen)
            classify = pwfms_pkg::PWFMS_SEQ_FIRST;
        else if (diff == '0)
            classify = pwfms_pkg::PWFMS_SEQ_INORDER;
        else if (!diff[`PWFMS_SEQ_W-1])
            classify = pwfms_pkg::PWFMS_SEQ_AHEAD;
        else
            classify = pwfms_pkg::PWFMS_SEQ_BEHIND;
    endfunction : classify

    logic [`PWFMS_SEQ_W-1:0]  expect_reg [FLOWS];
    logic [FLOWS-1:0]         seen_reg;
    pwfms_pkg::pwfms_seq_type rx_cls;
    logic                     rx_ok;
    logic                     rx_fwd;
    logic                     rx_gap;
    logic                     rx_late;

    assign rx_ok   = rx_valid && flow_in_range(rx_desc.flow);
    // a clear in the same cycle makes the arrival the first of its flow
    assign rx_cls  = classify(rx_desc.seq, expect_reg[rx_desc.flow],
                              seen_reg[rx_desc.flow] && !seq_reset);
    assign rx_fwd  = rx_ok && rx_cls != pwfms_pkg::PWFMS_SEQ_BEHIND;
    assign rx_gap  = rx_ok && rx_cls == pwfms_pkg::PWFMS_SEQ_AHEAD;
    // no reorder store: a late arrival is dropped at once
    assign rx_late = rx_ok && rx_cls == pwfms_pkg::PWFMS_SEQ_BEHIND;

    always_ff @(posedge mclk) begin
        if (srst) begin
            seen_reg <= '0;
        end else begin
            if (seq_reset) begin
                seen_reg <= '0;
            end
            // the arrival's set wins over a clear in the same cycle
            if (rx_fwd) begin
                seen_reg[rx_desc.flow] <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < FLOWS; i++) begin
                expect_reg[i] <= '0;
            end
        end else begin
            if (seq_reset) begin
                for (int i = 0; i < FLOWS; i++) begin
                    expect_reg[i] <= '0;
                end
            end
            // skipped numbers are passed and never forwarded later
            if (rx_fwd) begin
                expect_reg[rx_desc.flow] <= rx_desc.seq + SEQ_ONE;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            fwd_valid <= 1'b0;
            fwd_desc  <= '0;
            gap_event <= 1'b0;
            late_drop <= 1'b0;
        end else begin
            fwd_valid <= rx_fwd;
            gap_event <= rx_gap;
            late_drop <= rx_late;
            if (rx_ok) begin
                // queue chosen by inner flow, outer dscp ignored
                fwd_desc.queue  <= rx_desc.flow;
                fwd_desc.seq    <= rx_desc.seq;
                fwd_desc.length <= rx_desc.length;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            gap_count <= '0;
        end else if (rx_gap) begin
            gap_count <= sat_inc(gap_count);
        end
    end

endmodule : pwfms_top

`default_nettype wire

// file: common/pwfms_defines.svh
`ifndef PWFMS_DEFINES_SVH
`define PWFMS_DEFINES_SVH

`define PWFMS_DSCP_W       6
`define PWFMS_SEQ_W        16
`define PWFMS_LEN_W        16
`define PWFMS_FLOW_W       3
`define PWFMS_SESS_W       4
`define PWFMS_MTU_MIN      16'h07D0
`define PWFMS_MTU_RST      16'h07D0
`define PWFMS_DSCP_RST     6'h00
`define PWFMS_GAPCNT_W     16

`endif

// file: common/pwfms_pkg.sv
`include "pwfms_defines.svh"

package pwfms_pkg;

    typedef enum logic [1:0] {
        PWFMS_KIND_CTRL,
        PWFMS_KIND_SESS,
        PWFMS_KIND_FLOW
    } pwfms_kind_type;

    typedef enum logic [1:0] {
        PWFMS_SEQ_INORDER,
        PWFMS_SEQ_AHEAD,
        PWFMS_SEQ_BEHIND,
        PWFMS_SEQ_FIRST
    } pwfms_seq_type;

    // upstream transmit descriptor
    typedef struct packed {
        pwfms_kind_type                 kind;
        logic [`PWFMS_SESS_W-1:0]       session;
        logic [`PWFMS_FLOW_W-1:0]       flow;
        logic [`PWFMS_LEN_W-1:0]        length;
    } pwfms_tx_type;

    // upstream marked header fields
    typedef struct packed {
        logic [`PWFMS_DSCP_W-1:0]       dscp;
        logic                           dont_frag;
        logic [`PWFMS_SESS_W-1:0]       session;
        logic [`PWFMS_FLOW_W-1:0]       flow;
        logic [`PWFMS_LEN_W-1:0]        length;
    } pwfms_mark_type;

    // downstream arrival descriptor
    typedef struct packed {
        logic [`PWFMS_DSCP_W-1:0]       outer_dscp;
        logic [`PWFMS_FLOW_W-1:0]       flow;
        logic [`PWFMS_SEQ_W-1:0]        seq;
        logic [`PWFMS_LEN_W-1:0]        length;
    } pwfms_rx_type;

    // downstream forward descriptor
    typedef struct packed {
        logic [`PWFMS_FLOW_W-1:0]       queue;
        logic [`PWFMS_SEQ_W-1:0]        seq;
        logic [`PWFMS_LEN_W-1:0]        length;
    } pwfms_fwd_type;

endpackage : pwfms_pkg

// file: sim/pwfms_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module pwfms_sva (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        tx_valid,
    input wire logic        mark_valid,
    input wire logic        tx_oversize,
    input wire logic        rx_valid,
    input wire logic        fwd_valid,
    input wire logic        gap_event,
    input wire logic        late_drop,
    input wire logic [15:0] gap_count,
    input wire logic        adm_valid,
    input wire logic [15:0] adm_core_mtu,
    input wire logic [15:0] adm_need,
    input wire logic        adm_done,
    input wire logic        adm_refuse,
    input wire logic [15:0] adm_reply_mtu
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    tx_one_a: assert property (tx_valid |=> mark_valid ^ tx_oversize)
        else $error("tx answer wrong");
    tx_quiet_a: assert property (!tx_valid |=> !mark_valid && !tx_oversize)
        else $error("tx answer without request");
    rx_one_a: assert property (rx_valid |=> fwd_valid ^ late_drop)
        else $error("rx answer wrong");
    rx_quiet_a: assert property (!rx_valid |=> !fwd_valid && !late_drop && !gap_event)
        else $error("rx answer without arrival");
    late_drop_a: assert property (late_drop |-> !fwd_valid && !gap_event)
        else $error("late packet forwarded");
    gap_count_a: assert property (gap_event |-> fwd_valid &&
        (gap_count == $past(gap_count) + 16'h0001 || gap_count == 16'hFFFF))
        else $error("gap not counted or not forwarded");
    adm_check_a: assert property (adm_valid |=> adm_done && adm_refuse ==
        ($past(adm_need) > $past(adm_core_mtu) || $past(adm_core_mtu) < 16'h07D0))
        else $error("admission verdict wrong");
    refuse_hold_a: assert property (!adm_valid |=> $stable(adm_refuse))
        else $error("refuse changed without request");
    reply_min_a: assert property (adm_done |-> adm_reply_mtu >= 16'h07D0)
        else $error("reply mtu below minimum");

    cover property (gap_event);
    cover property (late_drop);
    cover property (adm_done && adm_refuse);
endmodule : pwfms_sva

bind pwfms_top pwfms_sva u_sva (.*);
`default_nettype wire

// file: sim/pwfms_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// core stand-in, downstream sender
// ----------------------------------------
module pwfms_core_model (
    input  wire logic                   mclk,
    output var pwfms_pkg::pwfms_rx_type rx_desc,
    output var logic                    rx_valid
);
    logic [15:0] nxt [8] = '{default: 16'h0000};

    initial begin
        rx_valid = 1'b0;
        rx_desc = '0;
    end

    // off 0 keeps order, above 0 skips, below 0 resends a passed position
    task automatic send(input logic [2:0] f, input int off, input logic [5:0] d,
                        input logic [15:0] len);
        @(posedge mclk) #1;
        rx_desc = {d, f, nxt[f] + 16'(off), len};
        rx_valid = 1'b1;
        if (off >= 0) nxt[f] = rx_desc.seq + 16'h0001;
        @(posedge mclk) #1;
        rx_valid = 1'b0;
        rx_desc = ~rx_desc;
    endtask : send
endmodule : pwfms_core_model
`default_nettype wire

// file: sim/test_pwfms.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// bench
// ----------------------------------------
module test_pseudowire_flow_marker_sequencer;
    logic        mclk, srst, sess_dscp_we, flow_phb_we, mtu_we, seq_reset;
    logic        adm_valid, adm_done, adm_refuse, tx_valid, mark_valid, tx_oversize;
    logic        rx_valid, fwd_valid, gap_event, late_drop;
    logic [5:0]  ctrl_dscp, sess_dscp_wdata, flow_phb_wdata;
    logic [3:0]  sess_dscp_waddr, mtu_waddr;
    logic [2:0]  flow_phb_waddr;
    logic [15:0] mtu_wdata, own_mtu, adm_core_mtu, adm_need, adm_reply_mtu, gap_count, gx;
    logic [31:0] rs;
    logic [5:0]  sd [16] = '{default: 6'h00};
    logic [5:0]  fd [8] = '{default: 6'h00};
    logic [15:0] mt [16] = '{default: 16'h07D0};
    logic        seen [8] = '{default: 1'b0};
    int          err_total, checks, off;
    pwfms_pkg::pwfms_tx_type   tx_desc;
    pwfms_pkg::pwfms_mark_type mark_desc;
    pwfms_pkg::pwfms_rx_type   rx_desc;
    pwfms_pkg::pwfms_fwd_type  fwd_desc;

    pwfms_top DUT (.*);
    pwfms_core_model core (.mclk(mclk), .rx_desc(rx_desc), .rx_valid(rx_valid));

    always #2.5 mclk = ~mclk;

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    function automatic logic over(input pwfms_pkg::pwfms_tx_type d);
        return d.kind != pwfms_pkg::PWFMS_KIND_CTRL && d.length > mt[d.session];
    endfunction : over

    function automatic logic [5:0] want(input pwfms_pkg::pwfms_tx_type d);
        if (d.kind == pwfms_pkg::PWFMS_KIND_CTRL) return ctrl_dscp;
        return d.kind == pwfms_pkg::PWFMS_KIND_SESS ? sd[d.session] : fd[d.flow];
    endfunction : want

    task automatic ck(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : ck

    task automatic conclude;
        $display("mismatches %0d comparisons %0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude

    // k selects the table: 0 session dscp, 1 flow dscp, 2 session mtu
    task automatic cfg(input int k, input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk) #1;
        {sess_dscp_waddr, mtu_waddr, flow_phb_waddr} = {a, a, a[2:0]};
        {sess_dscp_wdata, flow_phb_wdata, mtu_wdata} = {v[5:0], v[5:0], v};
        {sess_dscp_we, flow_phb_we, mtu_we} = 3'h4 >> k;
        @(posedge mclk) #1;
        {sess_dscp_we, flow_phb_we, mtu_we} = 3'h0;
        if (k == 0) sd[a] = v[5:0];
        if (k == 1) fd[a[2:0]] = v[5:0];
        if (k == 2) mt[a] = v;
    endtask : cfg

    task automatic tx(input pwfms_pkg::pwfms_tx_type d);
        @(posedge mclk) #1;
        tx_desc = d;
        tx_valid = 1'b1;
        @(posedge mclk) #1;
        tx_valid = 1'b0;
        ck(mark_valid === !over(d) && tx_oversize === over(d), "tx verdict");
        if (!over(d)) ck(mark_desc === {want(d), 1'b1, d[22:0]}, "mark");
    endtask : tx

    task automatic rx(input logic [2:0] f, input int off);
        logic g;
        logic l;
        logic [15:0] s;
        logic [15:0] n;
        if (!seen[f]) off = 0;
        g = seen[f] && off > 0;
        l = off < 0;
        rs = xs(rs);
        s = core.nxt[f] + 16'(off);
        n = {6'h00, rs[15:6]};
        core.send(f, off, rs[5:0], n);
        seen[f] = 1'b1;
        gx = gx + {15'h0000, g};
        ck(fwd_valid === !l && gap_event === g && late_drop === l, "rx");
        ck(gap_count === gx, "gaps");
        if (!l) ck(fwd_desc.queue === f, "queue");
        if (!l) ck(fwd_desc.seq === s && fwd_desc.length === n, "forward");
    endtask : rx

    task automatic adm(input logic [15:0] c, input logic [15:0] n, input logic [15:0] o);
        @(posedge mclk) #1;
        {adm_core_mtu, adm_need, own_mtu} = {c, n, o};
        adm_valid = 1'b1;
        @(posedge mclk) #1;
        adm_valid = 1'b0;
        ck(adm_done === 1'b1 && adm_refuse === (n > c || c < 16'h07D0), "admit");
        ck(adm_reply_mtu === (o > 16'h07D0 ? o : 16'h07D0), "reply");
    endtask : adm

    initial begin
        {srst, sess_dscp_we, flow_phb_we, mtu_we, seq_reset, adm_valid, tx_valid} = 7'h40;
        {ctrl_dscp, sess_dscp_wdata, flow_phb_wdata, sess_dscp_waddr, mtu_waddr} = '0;
        {flow_phb_waddr, mtu_wdata, own_mtu, adm_core_mtu, adm_need, tx_desc} = '0;
        {mclk, rs, gx, err_total, checks} = {1'b0, 32'h4082, 16'h0000, 64'h0};
        repeat (3) @(posedge mclk) #1;
        srst = 1'b0;
        ck(adm_reply_mtu === 16'h07D0 && gap_count === 16'h0000, "reset");
        tx({pwfms_pkg::PWFMS_KIND_SESS, 23'h0007D0});
        tx({pwfms_pkg::PWFMS_KIND_FLOW, 23'h0007D1});
        for (int i = 0; i < 16; i++) begin
            rs = xs(rs);
            cfg(0, i[3:0], rs[15:0]);
            cfg(1, i[3:0], rs[31:16]);
            cfg(2, i[3:0], 16'h07D0 + {6'h00, rs[9:0]});
        end
        ctrl_dscp = rs[27:22];
        repeat (80) begin
            rs = xs(rs);
            tx({pwfms_pkg::pwfms_kind_type'(rs[1:0] % 2'h3), rs[8:2], 16'h0600 + {5'h00, rs[30:20]}});
        end
        rx(3'h1, 0);
        rx(3'h1, 1);
        rx(3'h1, -2);
        repeat (80) begin
            rs = xs(rs);
            off = rs[4:3] == 2'h3 ? -1 : rs[4:3] == 2'h2 ? int'(rs[6:5]) + 1 : 0;
            rx(rs[2:0], off);
        end
        seq_reset = 1'b1;
        @(posedge mclk) #1;
        seq_reset = 1'b0;
        core.send(3'h1, 3, 6'h2E, 16'h0040);
        ck(fwd_valid === 1'b1 && gap_event === 1'b0, "restart");
        fork
            core.send(3'h2, 0, 6'h0A, 16'h0020);
            begin
                @(posedge mclk) #1;
                seq_reset = 1'b1;
                @(posedge mclk) #1;
                seq_reset = 1'b0;
            end
        join
        ck(fwd_valid === 1'b1 && gap_event === 1'b0, "clear with arrival");
        core.send(3'h2, -1, 6'h0A, 16'h0020);
        ck(late_drop === 1'b1 && fwd_valid === 1'b0, "resend after clear");
        adm(16'h07D0, 16'h07D0, 16'h0100);
        adm(16'h07CF, 16'h0010, 16'h0900);
        adm(16'h0900, 16'h0901, 16'h07D0);
        repeat (20) begin
            rs = xs(rs);
            adm(16'h0780 + {4'h0, rs[11:0]}, 16'h0700 + {4'h0, rs[23:12]}, {4'h0, rs[31:20]});
        end
        conclude;
    end

    initial begin
        #20000;
        err_total++;
        conclude;
    end
endmodule : test_pseudowire_flow_marker_sequencer
`default_nettype wire
